/* File: logic/xpc_pkg.sv */
// shared constants and types for the crosspoint serial configuration block
package xpc_pkg;
  localparam int OUTPUTS = 4;
  localparam int ADDR_W = 3;
  localparam int FRAME_W = 16;
  localparam int WORD_W = 6;
  localparam int SLOT_W = 4;
  // addressed word layout
  localparam int WORD_OUT_LSB = 0;
  localparam int WORD_IN_LSB = 2;
  localparam int WORD_OFF_BIT = 5;
  // frame slot layout per output
  localparam int SLOT_OFF_BIT = 3;
  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ROUTE = 4'h4;
  localparam logic [3:0] REG_STAGE = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  // control bits
  localparam int CTRL_APPLY_BIT = 0;
  localparam int CTRL_SHUT_BIT = 1;
  // status bits
  localparam int ST_PEND_BIT = 0;
  localparam int ST_ARMED_BIT = 1;
  localparam int ST_MODE_BIT = 2;
  localparam int ST_SEL_BIT = 3;
  localparam int ST_BCAST_BIT = 4;
  localparam int ST_RST_BIT = 5;
  localparam int STAGE_WORD_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [ADDR_W-1:0] INPUT_ZERO = 3'h0;

  // one output's routing setting
  typedef struct packed {
    logic off;
    logic [ADDR_W-1:0] sel;
  } xpc_route_type;

  // the seven documented control pins, after synchronising
  typedef struct packed {
    logic sclk;
    logic sdi;
    logic sel_n;
    logic apply;
    logic word_mode;
    logic clear;
    logic fanout_input_zero;
  } xpc_pins_type;
endpackage : xpc_pkg

/* File: logic/xpc_top.sv */
// serial routing configuration logic with an axi4-lite status port
//
// Overview of operation
// [RL1] select low enables the link; while high, clock and data are ignored
// [RL2] first clock rise after select low arms; next fall takes first bit
// [RL3] data taken on clock falls, serial out and select handled on rises
// [RL4] controller raises select or stops clock after the final bit
// [RL5] one hidden active register per output holds on/off and input address
// [RL6] staging bank is shift registers written only from the serial link
// [RL7] staged data reaches routing only when the apply strobe goes high
// [RL8] apply strobe works whatever the select level
// [RL9] apply without newly shifted data changes nothing
// [RL10] mode high: addressed word changes one output, others keep settings
// [RL11] mode low: sixteen bit frame reprograms all outputs
// [RL12] mode pin is a level, independent of select
// [RL13] each output takes one input; an input may feed many outputs
// [RL14] controller never enables two joined outputs of paired devices
// [RL15] frame shifts bit 0 first; extra clocks push old bits out serially
// [RL16] addressed word: two bit output, three bit input, off flag, lsb first
// [RL17] clear pin loads input 0 and disables all outputs while high; here a high broadcast pin still turns them all on
// [RL18] broadcast pin enables all outputs routed from input 0 while high
// [RL19] frame slot k: bits 4k..4k+2 input address, bit 4k+3 off flag
`timescale 1ns/100ps
`default_nettype none
module xpc_top
  import xpc_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst_n,
  // serial link and control pins, asynchronous to clk
  input wire logic link_sclk,
  input wire logic link_sdi,
  input wire logic link_sel_n,
  output logic link_sdo,
  input wire logic apply_pin,
  input wire logic word_mode,
  input wire logic clear_pin,
  input wire logic fanout_input_zero,
  // switching matrix drive
  output logic [OUTPUTS*ADDR_W-1:0] route_sel,
  output logic [OUTPUTS-1:0] route_on,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ---------------- pin synchronisers ----------------
  xpc_pins_type raw, meta, pins, pins_d;
  assign raw = '{sclk: link_sclk, sdi: link_sdi, sel_n: link_sel_n,
                 apply: apply_pin, word_mode: word_mode, clear: clear_pin,
                 fanout_input_zero: fanout_input_zero};

  // two stages, then one more copy for edge detection of the clean stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      pins <= '0;
      pins_d <= '0;
    end else begin
      meta <= raw;
      pins <= meta;
      pins_d <= pins;
    end
  end

  logic sclk_rise, sclk_fall, apply_rise;
  assign sclk_rise = pins.sclk & ~pins_d.sclk;
  assign sclk_fall = ~pins.sclk & pins_d.sclk;
  assign apply_rise = pins.apply & ~pins_d.apply;

  // ---------------- software control ----------------
  logic soft_apply, next_soft_apply;
  logic soft_shut, next_soft_shut;
  logic wr_fire;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // apply is a one-cycle pulse; shutdown is a held level
  always_comb begin
    next_soft_apply = 1'b0;
    next_soft_shut = soft_shut;
    if (wr_fire && wr_addr == REG_CTRL && wr_strb[0]) begin
      next_soft_apply = wr_data[CTRL_APPLY_BIT];
      next_soft_shut = wr_data[CTRL_SHUT_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_apply <= 1'b0;
      soft_shut <= 1'b0;
    end else begin
      soft_apply <= next_soft_apply;
      soft_shut <= next_soft_shut;
    end
  end

  logic do_apply, do_clear;
  assign do_apply = apply_rise | soft_apply; // RL8
  assign do_clear = pins.clear | soft_shut;

  // ---------------- serial link and staging bank ----------------
  logic armed, next_armed;
  logic [FRAME_W-1:0] frame_sr, next_frame_sr;
  logic [WORD_W-1:0] word_sr, next_word_sr;
  logic pend_frame, next_pend_frame;
  logic pend_word, next_pend_word;
  logic sdo, next_sdo;

  // bits only move on sampled falls while armed; a pending flag set in the
  // same cycle as an apply survives so no shifted bit is silently dropped
  always_comb begin
    next_armed = armed;
    next_frame_sr = frame_sr;
    next_word_sr = word_sr;
    next_pend_frame = pend_frame;
    next_pend_word = pend_word;
    next_sdo = sdo;
    if (do_apply) begin
      if (pins.word_mode) begin
        next_pend_word = 1'b0; // RL9
      end else begin
        next_pend_frame = 1'b0; // RL9
      end
    end
    if (pins.sel_n) begin
      next_armed = 1'b0; // RL1
    end else if (sclk_rise) begin
      next_armed = 1'b1; // RL2
      next_sdo = frame_sr[0]; // RL3
    end else if (sclk_fall && armed) begin
      if (pins.word_mode) begin
        next_word_sr = {pins.sdi, word_sr[WORD_W-1:1]}; // RL16
        next_pend_word = 1'b1;
      end else begin
        next_frame_sr = {pins.sdi, frame_sr[FRAME_W-1:1]}; // RL15
        next_pend_frame = 1'b1;
      end
    end
  end

  // staging bank is written from the link only, never from the bus, which can only read it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
      frame_sr <= '0;
      word_sr <= '0;
      pend_frame <= 1'b0;
      pend_word <= 1'b0;
      sdo <= 1'b0;
    end else begin
      armed <= next_armed;
      frame_sr <= next_frame_sr; // RL6
      word_sr <= next_word_sr; // RL6
      pend_frame <= next_pend_frame;
      pend_word <= next_pend_word;
      sdo <= next_sdo;
    end
  end

  assign link_sdo = sdo;

  // ---------------- active bank and matrix drive ----------------
  xpc_route_type active [OUTPUTS];
  xpc_route_type next_active [OUTPUTS];
  logic [OUTPUTS*ADDR_W-1:0] next_route_sel;
  logic [OUTPUTS-1:0] next_route_on;
  logic [1:0] word_out;

  assign word_out = word_sr[WORD_OUT_LSB +: 2];

  // one setting per output means one input per output by construction,
  // while nothing stops several outputs from naming the same input
  always_comb begin
    for (int k = 0; k < OUTPUTS; k++) begin
      next_active[k] = active[k];
      if (do_clear) begin
        next_active[k] = '{off: 1'b1, sel: INPUT_ZERO}; // RL17
      end else if (do_apply && !pins.word_mode && pend_frame) begin
        next_active[k] = '{off: frame_sr[k*SLOT_W+SLOT_OFF_BIT],
                           sel: frame_sr[k*SLOT_W +: ADDR_W]}; // RL19
      end else if (do_apply && pins.word_mode && pend_word &&
                   word_out == 2'(k)) begin
        next_active[k] = '{off: word_sr[WORD_OFF_BIT],
                           sel: word_sr[WORD_IN_LSB +: ADDR_W]}; // RL10
      end
      // broadcast overrides the drive only, the active bank is kept
      if (pins.fanout_input_zero) begin
        next_route_sel[k*ADDR_W +: ADDR_W] = INPUT_ZERO; // RL18
        next_route_on[k] = 1'b1; // RL18
      end else begin
        next_route_sel[k*ADDR_W +: ADDR_W] = do_clear ? INPUT_ZERO
                                                      : active[k].sel; // RL13
        next_route_on[k] = ~active[k].off & ~do_clear;
      end
    end
  end

  // the active bank takes no bus data, though a bus apply or shutdown still loads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < OUTPUTS; k++) begin
        active[k] <= '{off: 1'b1, sel: INPUT_ZERO};
      end
      route_sel <= '0;
      route_on <= '0;
    end else begin
      for (int k = 0; k < OUTPUTS; k++) begin
        active[k] <= next_active[k]; // RL5 RL7 RL11
      end
      route_sel <= next_route_sel;
      route_on <= next_route_on;
    end
  end

  // ---------------- axi4-lite slave ----------------
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [3:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic awready, next_awready, wready, next_wready, arready, next_arready;
  logic [FRAME_W-1:0] route_word;

  // packed view of the active bank in frame layout
  always_comb begin
    for (int k = 0; k < OUTPUTS; k++) begin
      route_word[k*SLOT_W +: SLOT_W] = {active[k].off, active[k].sel};
    end
  end

  assign wr_fire = aw_held & w_held & ~bvalid;
  assign wr_addr = aw_addr;
  assign wr_data = w_data;
  assign wr_strb = w_strb;

  // address and data are held separately, in either order; one write
  // and one read at a time keeps the slave free of queues
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      unique case (s_axi_araddr)
        REG_CTRL: next_rdata[CTRL_SHUT_BIT] = soft_shut;
        REG_ROUTE: next_rdata[FRAME_W-1:0] = route_word;
        REG_STAGE: begin
          next_rdata[FRAME_W-1:0] = frame_sr;
          next_rdata[STAGE_WORD_LSB +: WORD_W] = word_sr;
        end
        REG_STATUS: begin
          next_rdata[ST_PEND_BIT] = pins.word_mode ? pend_word : pend_frame;
          next_rdata[ST_ARMED_BIT] = armed;
          next_rdata[ST_MODE_BIT] = pins.word_mode; // RL12
          next_rdata[ST_SEL_BIT] = ~pins.sel_n;
          next_rdata[ST_BCAST_BIT] = pins.fanout_input_zero;
          next_rdata[ST_RST_BIT] = do_clear;
        end
        default: next_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready = ~next_w_held & ~next_bvalid;
    next_arready = ~next_rvalid;
  end

  // readies are registered so every bus output leaves a flip-flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      awready <= next_awready;
      wready <= next_wready;
      arready <= next_arready;
    end
  end

  assign s_axi_awready = awready;
  assign s_axi_wready = wready;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = arready;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

endmodule : xpc_top
`default_nettype wire

/* File: sim/xpc_link_model.sv */
// behavioural serial controller driving the link pins
`timescale 1ns/100ps
`default_nettype none
module xpc_link_model (
  // frame request from the bench
  input wire logic go,
  input wire logic [15:0] frame,
  input wire logic [4:0] nbits,
  input wire logic keep_sel,
  input wire logic noise,
  // link pins
  output logic link_sclk,
  output logic link_sdi,
  output logic link_sel_n,
  output logic busy
);
  initial begin
    link_sclk = 1'b0;
    link_sdi = 1'b0;
    link_sel_n = 1'b1;
    busy = 1'b0;
  end
  // first rise arms, each fall takes one bit, bit 0 first
  always @(posedge go) begin
    busy = 1'b1;
    #3 link_sel_n = noise; // noise clocks with select left high
    for (int i = 0; i < nbits; i++) begin
      #40 link_sclk = 1'b1;
      // data moves on the rise so it is settled long before the taking fall
      link_sdi = frame[i];
      #40 link_sclk = 1'b0;
    end
    // clock parked low; select raised unless held for a later apply
    #40 if (!keep_sel) link_sel_n = 1'b1;
    link_sdi = ~link_sdi; // released data must not show the last bit
    busy = 1'b0;
  end
endmodule : xpc_link_model
`default_nettype wire

/* File: sim/xpc_top_sva.sv */
// port assertions for the crosspoint configuration block
`timescale 1ns/100ps
`default_nettype none
module xpc_top_sva
  import xpc_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst_n,
  // link and control pins
  input wire logic link_sclk,
  input wire logic link_sel_n,
  input wire logic link_sdo,
  input wire logic apply_pin,
  input wire logic clear_pin,
  input wire logic fanout_input_zero,
  // routing
  input wire logic [OUTPUTS*ADDR_W-1:0] route_sel,
  input wire logic [OUTPUTS-1:0] route_on,
  // bus
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [3:0] quiet;
  logic [3:0] next_quiet;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // cycles since anything that may move the routing; saturates
  always_comb begin
    next_quiet = quiet + {3'h0, quiet != 4'hF};
    if (apply_pin | clear_pin | fanout_input_zero | s_axi_wvalid) begin
      next_quiet = 4'h0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) quiet <= 4'h0;
    else quiet <= next_quiet;
  end
  chk_clear_off: assert property (
    (clear_pin && !fanout_input_zero)[*8] |-> route_on == 4'h0
      && route_sel == 12'h000) else $error("clear left routing on");
  chk_bcast_all: assert property (
    (fanout_input_zero && !clear_pin)[*8] |-> route_on == 4'hF
      && route_sel == 12'h000) else $error("broadcast not from input 0");
  chk_route_quiet: assert property (
    quiet > 4'h8 |-> $stable(route_on) && $stable(route_sel))
    else $error("routing moved without a cause");
  chk_sdo_idle: assert property (
    link_sel_n[*8] |-> $stable(link_sdo)) else $error("sdo moved unselected");
  chk_sdo_rise: assert property (
    $changed(link_sdo) |-> $past(link_sclk, 2) || $past(link_sclk, 3)
      || $past(link_sclk, 4)) else $error("sdo moved off a clock rise");
  chk_read_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_done: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
  chk_write_done: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  cov_bcast: cover property (route_on == 4'hF);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
  cov_sdo: cover property ($changed(link_sdo));
endmodule : xpc_top_sva
bind xpc_top xpc_top_sva u_sva (.clk, .rst_n, .link_sclk, .link_sel_n,
  .link_sdo, .apply_pin, .clear_pin, .fanout_input_zero, .route_sel,
  .route_on, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the crosspoint configuration block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import xpc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, apply_pin = 1'b0, word_mode = 1'b0;
  logic clear_pin = 1'b0, fanout_input_zero = 1'b0, go = 1'b0;
  logic keep_sel = 1'b0, noise = 1'b0, link_sclk, link_sdi, link_sel_n;
  logic link_sdo, busy;
  logic [15:0] frame = 16'h0000, fr_a, cur_x, last_rt = 16'h0000;
  logic [4:0] nbits = 5'h00;
  logic [5:0] wd;
  logic [11:0] route_sel;
  logic [3:0] route_on, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'hEC8D;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] rq[$];
  logic [33:0] bq[$];
  int bad_count = 0, compares = 0;
  xpc_top DUT (.clk, .rst_n, .link_sclk, .link_sdi, .link_sel_n, .link_sdo,
    .apply_pin, .word_mode, .clear_pin, .fanout_input_zero, .route_sel,
    .route_on, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  xpc_link_model link (.go, .frame, .nbits, .keep_sel, .noise, .link_sclk,
    .link_sdi, .link_sel_n, .busy);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check_route(input logic [15:0] got, input logic [15:0] ex);
    compares++;
    if (got !== ex) begin
      bad_count++;
      $display("MISMATCH %0t routing %h expected %h", $time, got, ex);
    end
  endtask : check_route
  task automatic check_bus(input logic [33:0] got, input logic [33:0] ex);
    compares++;
    if (got !== ex) begin
      bad_count++;
      $display("MISMATCH %0t bus %h expected %h", $time, got, ex);
    end
  endtask : check_bus
  task automatic check_sdo(input logic got, input logic ex);
    compares++;
    if (got !== ex) begin
      bad_count++;
      $display("MISMATCH %0t serial out %b expected %b", $time, got, ex);
    end
  endtask : check_sdo
  task automatic report_and_stop;
    if (rq.size() != 0 || bq.size() != 0) bad_count++;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic give_up(input int t);
    if (t >= 400) begin
      bad_count++;
      $display("MISMATCH %0t wait ran out", $time);
      report_and_stop();
    end
  endtask : give_up
  function automatic void step();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction : step
  // frame slot k: three address bits then an active-low enable
  function automatic logic [15:0] to_route(input logic [15:0] f);
    logic [15:0] r;
    for (int k = 0; k < OUTPUTS; k++) begin
      r[12 + k] = ~f[4 * k + 3];
      r[3 * k +: 3] = f[4 * k +: 3];
    end
    return r;
  endfunction : to_route
  // watcher: every change of drive or bus answer takes the oldest note
  always @(posedge clk) begin
    if (rst_n && {route_on, route_sel} !== last_rt) begin
      check_route({route_on, route_sel},
        rq.size() != 0 ? rq.pop_front() : ~{route_on, route_sel});
      last_rt = {route_on, route_sel};
    end
    if (s_axi_bvalid && s_axi_bready)
      check_bus({s_axi_bresp, 32'h0}, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      check_bus({s_axi_rresp, s_axi_rdata}, bq.pop_front());
  end
  task automatic send(input logic [15:0] d, input logic [4:0] n,
      input logic ks, input logic nz);
    int t = 0;
    @(posedge clk);
    frame <= d;
    nbits <= n;
    keep_sel <= ks;
    noise <= nz;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (busy !== 1'b0 && t < 400) begin
      @(posedge clk);
      t++;
    end
    give_up(t);
  endtask : send
  task automatic pulse_apply;
    @(posedge clk);
    apply_pin <= 1'b1;
    repeat (6) @(posedge clk);
    apply_pin <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : pulse_apply
  // one bus transfer; each channel held until its own ready
  task automatic axi(input logic wr, input logic [3:0] a,
      input logic [31:0] d, input logic [33:0] ex);
    int t = 0;
    bq.push_back(ex);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(posedge clk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (t < 400 && (s_axi_bready || s_axi_rready));
    give_up(t);
  endtask : axi
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check_route({route_on, route_sel}, 16'h0000);
    $display("test reset done");
    // full frame, applied with select still low, then applied again
    step();
    // a single device here, so no joined outputs can ever be on together
    fr_a = seed[15:0];
    send(fr_a, 5'd16, 1'b1, 1'b0);
    repeat (10) @(posedge clk);
    cur_x = to_route(fr_a);
    rq.push_back(cur_x);
    pulse_apply();
    pulse_apply();
    axi(1'b0, REG_ROUTE, 32'h0, {RESP_OKAY, 16'h0000, fr_a});
    $display("test frame done");
    // addressed words toggle one output each, applied over the bus
    word_mode <= 1'b1;
    for (int o = 0; o < OUTPUTS; o++) begin
      step();
      wd = {cur_x[12 + o], seed[2:0], o[1:0]};
      send({10'h000, wd}, 5'd6, 1'b0, 1'b0);
      cur_x[12 + o] = ~wd[5];
      cur_x[3 * o +: 3] = wd[4:2];
      rq.push_back(cur_x);
      axi(1'b1, REG_CTRL, 32'h1, {RESP_OKAY, 32'h0});
      repeat (8) @(posedge clk);
    end
    // word clocks still move the serial out from the parked frame's bit 0
    check_sdo(link_sdo, fr_a[0]);
    axi(1'b0, REG_STAGE, 32'h0, {RESP_OKAY, 10'h000, wd, fr_a});
    $display("test addressed done");
    // clocking with select high must leave nothing to apply
    word_mode <= 1'b0;
    step();
    send(seed[15:0], 5'd16, 1'b0, 1'b1);
    pulse_apply();
    $display("test deselected done");
    // clear, then broadcast over the cleared bank
    rq.push_back(16'h0000);
    rq.push_back(16'hF000);
    rq.push_back(16'h0000);
    clear_pin <= 1'b1;
    repeat (10) @(posedge clk);
    clear_pin <= 1'b0;
    repeat (10) @(posedge clk);
    fanout_input_zero <= 1'b1;
    repeat (10) @(posedge clk);
    fanout_input_zero <= 1'b0;
    repeat (10) @(posedge clk);
    axi(1'b1, REG_ROUTE, 32'hFFFF, {RESP_SLVERR, 32'h0});
    axi(1'b0, REG_ROUTE, 32'h0, {RESP_OKAY, 32'h00008888});
    $display("test overrides done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
